// ==== hw/drac_defines.svh ====
// constants of the dram refresh and access controller
`ifndef DRAC_DEFINES_SVH
`define DRAC_DEFINES_SVH

// ************************************************
// refresh divisors, indexed by {source strap, edge strap}
// ************************************************
`define DRAC_DIV_LL        8'd61
`define DRAC_DIV_LH        8'd136
`define DRAC_DIV_HL        8'd91
`define DRAC_DIV_HH        8'd121

// ************************************************
// sequencing counts in device clock cycles, then array sizes and refresh timing
// ************************************************
`define DRAC_REF_CYC_LOW   3'd3
`define DRAC_REF_CYC       3'd4
`define DRAC_CALIB_CYC     4'd15
`define DRAC_STRAP_HOLD    4'd4
`define DRAC_ROWS          512
`define DRAC_WINDOW_MS     8
`define DRAC_ROW_PERIOD_US 13.6
`define DRAC_ADDR_W        10
`define DRAC_BANKS         4

`endif

// ==== hw/drac_pkg.sv ====
// types of the dram refresh and access controller
package drac_pkg;
  typedef enum logic [2:0] {
    ST_CALIB,
    ST_IDLE,
    ST_REFRESH,
    ST_ACC_ROW,
    ST_ACC_COL
  } drac_state_t;
endpackage

// ==== hw/drac_timer_if.sv ====
// carrier between the controller and its refresh timer
`timescale 1ns/1ps
`default_nettype none
interface drac_timer_if;
  logic       tick;
  logic       enable;
  logic [7:0] divisor;
  logic       done;
  logic       req;
  logic [8:0] row;
  modport ctrl  (output tick, enable, divisor, done, input req, row);
  modport timer (input tick, enable, divisor, done, output req, row);
endinterface
`default_nettype wire

// ==== hw/drac_refresh_timer.sv ====
// refresh divider and row refresh counter
`timescale 1ns/1ps
`default_nettype none
`include "drac_defines.svh"
module drac_refresh_timer #(
  parameter int ROWS = `DRAC_ROWS
) (
  input  wire logic   clk,
  input  wire logic   reset_n,
  drac_timer_if.timer tif
);
  logic [7:0] divCnt_reg;
  logic       req_reg;
  logic [8:0] row_reg;

  // ************************************************
  // divider
  // ************************************************
  // device clock ticks divided by divisor
  always_ff @(posedge clk) begin
    if (!reset_n || !tif.enable) begin
      divCnt_reg <= 8'h00;
      req_reg    <= 1'b0;
    end else if (tif.tick) begin
      if (divCnt_reg >= tif.divisor - 8'h01) begin
        divCnt_reg <= 8'h00;
        req_reg    <= 1'b1;
      end else begin
        divCnt_reg <= divCnt_reg + 8'h01;
        req_reg    <= 1'b0;
      end
    end else begin
      req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      row_reg <= 9'h000;
    end else if (tif.done) begin
      row_reg <= (row_reg == 9'(ROWS - 1)) ? 9'h000 : row_reg + 9'h001;
    end
  end

  assign tif.req = req_reg;
  assign tif.row = row_reg;

  timerOff_a: assert property (@(posedge clk) disable iff (!reset_n)
    !tif.enable |=> !tif.req) else $error("refresh timer fired while disabled");
  divWrap_a: assert property (@(posedge clk) disable iff (!reset_n)
    tif.req |-> divCnt_reg == 8'h00) else $error("divider did not wrap on request");
endmodule
`default_nettype wire

// ==== hw/drac_ctrl.sv ====
// top of the dram refresh and access controller
`timescale 1ns/1ps
`default_nettype none
`include "drac_defines.svh"
module drac_ctrl #(
  parameter int ADDR_W = `DRAC_ADDR_W,
  parameter int BANKS  = `DRAC_BANKS
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              devClk,
  input  wire logic              arbEdgeStrap,
  input  wire logic              refreshSourceStrap,
  input  wire logic              hostAddrStrobe_n,
  input  wire logic [ADDR_W-1:0] rowAddrIn,
  input  wire logic [ADDR_W-1:0] colAddrIn,
  input  wire logic [1:0]        bankSel,
  input  wire logic              extRefreshReq,
  output logic      [ADDR_W-1:0] dramAddr,
  output logic                   dramRas_n,
  output logic      [BANKS-1:0]  dramCas_n,
  output logic                   ready,
  output logic                   accessGrant,
  output logic                   refreshActive
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  // three flops per pin; stable value moves only when second and third agree
  logic [4:0] s1_reg, s2_reg, s3_reg, stable_reg;
  logic [4:0] pinsIn;
  assign pinsIn = {extRefreshReq, hostAddrStrobe_n, refreshSourceStrap, arbEdgeStrap, devClk};
  always_ff @(posedge clk) begin
    s1_reg <= pinsIn;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_stable
      always_ff @(posedge clk) begin
        if (s2_reg[gi] == s3_reg[gi]) begin
          stable_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  logic devStable_d, strobeStable_d, extStable_d;
  always_ff @(posedge clk) begin
    devStable_d    <= stable_reg[0];
    strobeStable_d <= stable_reg[3];
    extStable_d    <= stable_reg[4];
  end
  logic devRise, devFall, strobeFall, extRise;
  assign devRise    = stable_reg[0] & ~devStable_d;
  assign devFall    = ~stable_reg[0] & devStable_d;
  assign strobeFall = ~stable_reg[3] & strobeStable_d;
  assign extRise    = stable_reg[4] & ~extStable_d;

  // ************************************************
  // strap latch
  // ************************************************
  logic modeRise_reg, modeExt_reg;
  // last value seen while reset is low wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modeRise_reg <= stable_reg[1];
      modeExt_reg  <= stable_reg[2];
    end
  end

  logic arbTick;
  assign arbTick = modeRise_reg ? devRise : devFall;

  // live straps pick the divisor after reset
  logic [7:0] divisor;
  logic [2:0] refCycles;
  always_comb begin
    unique case (stable_reg[2:1])
      2'b00: divisor = `DRAC_DIV_LL;
      2'b01: divisor = `DRAC_DIV_LH;
      2'b10: divisor = `DRAC_DIV_HL;
      2'b11: divisor = `DRAC_DIV_HH;
    endcase
    refCycles = (divisor == `DRAC_DIV_LL) ? `DRAC_REF_CYC_LOW : `DRAC_REF_CYC;
  end

  // ************************************************
  // refresh timer
  // ************************************************
  drac_timer_if tif ();
  drac_pkg::drac_state_t state_reg;
  logic [2:0] refCnt_reg;
  logic refDone;
  assign refDone     = (state_reg == drac_pkg::ST_REFRESH) && arbTick
                       && (refCnt_reg == refCycles - 3'd1);
  assign tif.tick    = devRise;
  // internal timer disabled in external mode
  assign tif.enable  = ~modeExt_reg;
  assign tif.divisor = divisor;
  assign tif.done    = refDone;
  drac_refresh_timer #(.ROWS(`DRAC_ROWS)) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  // ************************************************
  // pending requests
  // ************************************************
  logic refPend_reg, accPend_reg, accStart;
  logic [ADDR_W-1:0] rowLat_reg, colLat_reg;
  logic [1:0]        bankLat_reg;
  assign accStart = (state_reg == drac_pkg::ST_IDLE) && arbTick && accPend_reg && !refPend_reg;
  // request source by mode; a new request wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refPend_reg <= 1'b0;
    end else if (modeExt_reg ? extRise : tif.req) begin
      refPend_reg <= 1'b1;
    end else if (state_reg == drac_pkg::ST_IDLE && arbTick && refPend_reg) begin
      refPend_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accPend_reg <= 1'b0;
      rowLat_reg  <= '0;
      colLat_reg  <= '0;
      bankLat_reg <= 2'h0;
    end else if (strobeFall) begin
      accPend_reg <= 1'b1;
      rowLat_reg  <= rowAddrIn;
      colLat_reg  <= colAddrIn;
      bankLat_reg <= bankSel;
    end else if (accStart) begin
      accPend_reg <= 1'b0;
    end
  end

  // ************************************************
  // sequencer
  // ************************************************
  logic [3:0] calCnt_reg;
  logic       afterRef_reg;
  // refresh and calibration finish before an access starts
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg  <= drac_pkg::ST_CALIB;
      calCnt_reg <= 4'h0;
      refCnt_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        drac_pkg::ST_CALIB: begin
          if (devRise) begin
            calCnt_reg <= calCnt_reg + 4'h1;
            if (calCnt_reg == `DRAC_CALIB_CYC - 4'h1) begin
              state_reg <= drac_pkg::ST_IDLE;
            end
          end
        end
        drac_pkg::ST_IDLE: begin
          refCnt_reg <= 3'h0;
          if (arbTick && refPend_reg) begin
            state_reg <= drac_pkg::ST_REFRESH;
          end else if (accStart) begin
            state_reg <= drac_pkg::ST_ACC_ROW;
          end
        end
        drac_pkg::ST_REFRESH: begin
          // refresh length 3 or 4 cycles
          if (refDone) begin
            state_reg <= drac_pkg::ST_IDLE;
          end else if (arbTick) begin
            refCnt_reg <= refCnt_reg + 3'h1;
          end
        end
        drac_pkg::ST_ACC_ROW: begin
          if (arbTick) begin
            state_reg <= drac_pkg::ST_ACC_COL;
          end
        end
        drac_pkg::ST_ACC_COL: begin
          if (stable_reg[3]) begin
            state_reg <= drac_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // access straight after refresh or calibration is a grant cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      afterRef_reg <= 1'b0;
    end else if (refDone || state_reg == drac_pkg::ST_CALIB) begin
      afterRef_reg <= 1'b1;
    end else if (state_reg == drac_pkg::ST_ACC_COL && stable_reg[3]) begin
      afterRef_reg <= 1'b0;
    end else if (state_reg == drac_pkg::ST_IDLE && arbTick && !accPend_reg) begin
      afterRef_reg <= 1'b0;
    end
  end

  // ************************************************
  // dram outputs
  // ************************************************
  // row first, column second; one column strobe per bank
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dramAddr      <= '0;
      dramRas_n     <= 1'b1;
      dramCas_n     <= '1;
      refreshActive <= 1'b0;
      accessGrant   <= 1'b0;
    end else begin
      dramRas_n     <= 1'b1;
      dramCas_n     <= '1;
      refreshActive <= 1'b0;
      accessGrant   <= 1'b0;
      unique case (state_reg)
        drac_pkg::ST_REFRESH: begin
          dramAddr      <= ADDR_W'(tif.row);
          dramRas_n     <= 1'b0;
          refreshActive <= 1'b1;
        end
        drac_pkg::ST_ACC_ROW: begin
          dramAddr    <= rowLat_reg;
          dramRas_n   <= 1'b0;
          accessGrant <= afterRef_reg;
        end
        drac_pkg::ST_ACC_COL: begin
          dramAddr             <= colLat_reg;
          dramRas_n            <= 1'b0;
          dramCas_n[bankLat_reg] <= 1'b0;
          accessGrant          <= afterRef_reg;
        end
        default: begin
          dramAddr <= dramAddr;
        end
      endcase
    end
  end

  // ready low while an access waits on refresh or calibration
  assign ready = !(accPend_reg && (state_reg == drac_pkg::ST_REFRESH
                                   || state_reg == drac_pkg::ST_CALIB));

  // ************************************************
  // checks
  // ************************************************
  sequence refEndSeq;
    refDone && accPend_reg;
  endsequence
  sequence rowStepSeq;
    state_reg == drac_pkg::ST_ACC_ROW && arbTick;
  endsequence

  // leaving idle only on the arbitration edge
  arbEdge_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == drac_pkg::ST_IDLE && !arbTick |=> state_reg == drac_pkg::ST_IDLE)
    else $error("left idle off the arbitration edge");
  // refresh never runs past its length
  refLen_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == drac_pkg::ST_REFRESH |-> refCnt_reg < refCycles)
    else $error("refresh ran too long");
  rowCol_a: assert property (@(posedge clk) disable iff (!reset_n)
    rowStepSeq |=> state_reg == drac_pkg::ST_ACC_COL ##1 dramAddr == colLat_reg)
    else $error("column did not follow row");
  oneBank_a: assert property (@(posedge clk) disable iff (!reset_n)
    $countones(~dramCas_n) <= 1) else $error("more than one column strobe low");
  accAfterRef_a: assert property (@(posedge clk) disable iff (!reset_n)
    refEndSeq |=> state_reg == drac_pkg::ST_IDLE && afterRef_reg)
    else $error("waiting access lost after refresh");
  readyBack_a: assert property (@(posedge clk) disable iff (!reset_n)
    refEndSeq |-> !ready ##1 ready) else $error("ready not restored after refresh");
  calQuiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == drac_pkg::ST_CALIB |=> dramRas_n) else $error("row strobe in calibration");
  // ready high through a normal access
  normReady_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == drac_pkg::ST_ACC_COL |-> ready) else $error("ready low in normal access");
  grantFlag_a: assert property (@(posedge clk) disable iff (!reset_n)
    accessGrant |-> $past(afterRef_reg)) else $error("grant flagged without refresh");
endmodule
`default_nettype wire

// ==== tb/drac_host_model.sv ====
// host bus and write logic model facing the dram controller
`timescale 1ns/1ps
`default_nettype none
module drac_host_model (
  input  wire logic       clk,
  output logic            devClk,
  output logic            hostAddrStrobe_n,
  output logic [9:0]      rowAddrIn,
  output logic [9:0]      colAddrIn,
  output logic [1:0]      bankSel,
  input  wire logic [3:0] dramCas_n,
  output logic            writeStrobe_n
);
  logic [1:0] divCnt;

  initial begin
    devClk = 1'b0;
    divCnt = 2'h0;
    hostAddrStrobe_n = 1'b1;
    writeStrobe_n = 1'b1;
    rowAddrIn = 10'h000;
    colAddrIn = 10'h000;
    bankSel = 2'h0;
  end

  // device clock at a quarter of the bus clock
  always @(posedge clk) begin
    divCnt <= divCnt + 2'h1;
    if (divCnt[0]) devClk <= ~devClk;
  end

  task automatic access(input logic [9:0] row, input logic [9:0] col,
                        input logic [1:0] bank, output logic ok);
    int n;
    @(posedge clk);
    rowAddrIn <= row;
    colAddrIn <= col;
    bankSel <= bank;
    writeStrobe_n <= 1'b0;
    hostAddrStrobe_n <= 1'b0;
    n = 0;
    while (dramCas_n[bank] !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    hostAddrStrobe_n <= 1'b1;
    writeStrobe_n <= 1'b1;
    // released address lines must not look valid
    rowAddrIn <= ~row;
    colAddrIn <= ~col;
    repeat (8) @(posedge clk);
    ok = (n < 400);
  endtask
endmodule
`default_nettype wire

// ==== tb/drac_ctrl_test.sv ====
// self-checking bench of the dram refresh and access controller
`timescale 1ns/1ps
`default_nettype none
module drac_ctrl_test;
  logic       clk, reset_n, arbEdgeStrap, refreshSourceStrap, extRefreshReq;
  logic       devClk, hostAddrStrobe_n, writeStrobe_n, dramRas_n, ready;
  logic       accessGrant, refreshActive, rasPrev, sawReadyLow, sawGrant, casRef, ok;
  logic [9:0] rowAddrIn, colAddrIn, dramAddr, rasAddr, casAddr, refRow;
  logic [1:0] bankSel;
  logic [3:0] dramCas_n, casPrev, casSeen;
  int         mismatches, checks_done, cycles;

  drac_ctrl drac_ctrl_inst (.clk(clk), .reset_n(reset_n), .devClk(devClk),
    .arbEdgeStrap(arbEdgeStrap), .refreshSourceStrap(refreshSourceStrap),
    .hostAddrStrobe_n(hostAddrStrobe_n), .rowAddrIn(rowAddrIn), .colAddrIn(colAddrIn),
    .bankSel(bankSel), .extRefreshReq(extRefreshReq), .dramAddr(dramAddr),
    .dramRas_n(dramRas_n), .dramCas_n(dramCas_n), .ready(ready),
    .accessGrant(accessGrant), .refreshActive(refreshActive));
  drac_host_model drac_host_model_inst (.clk(clk), .devClk(devClk),
    .hostAddrStrobe_n(hostAddrStrobe_n), .rowAddrIn(rowAddrIn), .colAddrIn(colAddrIn),
    .bankSel(bankSel), .dramCas_n(dramCas_n), .writeStrobe_n(writeStrobe_n));

  // ****************************************
  // clock, monitor and timeout
  // ****************************************
  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    rasPrev <= dramRas_n;
    casPrev <= dramCas_n;
    if (rasPrev && !dramRas_n) rasAddr <= dramAddr;
    if (rasPrev && !dramRas_n && refreshActive) refRow <= dramAddr;
    if (casPrev == 4'hf && dramCas_n != 4'hf) begin
      casAddr <= dramAddr;
      casSeen <= dramCas_n;
      casRef <= refreshActive;
    end
    if (!hostAddrStrobe_n && ready === 1'b0) sawReadyLow <= 1'b1;
    if (!hostAddrStrobe_n && accessGrant === 1'b1) sawGrant <= 1'b1;
    // whole run needs well under this many cycles
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_ref(input logic lvl);
    int n;
    n = 0;
    while (refreshActive !== lvl && n < 1200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1200) check("refresh wait", 1'b0, 1'b1);
  endtask

  task automatic do_access(input logic [9:0] row, input logic [9:0] col, input logic [1:0] b);
    sawReadyLow = 1'b0;
    sawGrant = 1'b0;
    drac_host_model_inst.access(row, col, b, ok);
    check("access done", ok, 1'b1);
    check("row addr", rasAddr, row);
    check("col addr", casAddr, col);
    // cast keeps the inverted mask at four bits, not the argument's 32
    check("bank strobe", casSeen, 4'(~(4'h1 << b)));
  endtask

  task automatic measure(input int expLen, input int expPer);
    int len, per;
    wait_ref(1'b1);
    len = 0;
    per = 0;
    while (refreshActive === 1'b1 && per < 2000) begin
      @(posedge clk);
      len++;
      per++;
    end
    while (refreshActive !== 1'b1 && per < 2000) begin
      @(posedge clk);
      per++;
    end
    check("refresh length", len, expLen);
    check("refresh period", per, expPer);
  endtask

  task automatic do_reset(input logic edgeS, input logic srcS);
    @(posedge clk);
    reset_n <= 1'b0;
    arbEdgeStrap <= edgeS;
    refreshSourceStrap <= srcS;
    // straps settle through the pin synchronisers before release
    repeat (24) @(posedge clk);
    check("ras in reset", dramRas_n, 1'b1);
    check("cas in reset", dramCas_n, 4'hf);
    reset_n <= 1'b1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_calib;
    do_access(10'h2a5, 10'h15a, 2'd2);
    check("wait in calibration", sawReadyLow, 1'b1);
    check("grant after calibration", sawGrant, 1'b1);
    $display("test calib done");
  endtask

  task automatic t_normal;
    for (int b = 0; b < 4; b++) begin
      wait_ref(1'b1);
      wait_ref(1'b0);
      repeat (16) @(posedge clk);
      do_access(10'h3ff - 10'(b), 10'(b * 5 + 1), 2'(b));
      check("ready stays high", sawReadyLow, 1'b0);
      check("normal not grant", sawGrant, 1'b0);
    end
    $display("test normal done");
  endtask

  task automatic t_during;
    wait_ref(1'b1);
    do_access(10'h0c3, 10'h33c, 2'd1);
    check("cas after refresh", casRef, 1'b0);
    check("grant wait", sawReadyLow, 1'b1);
    check("grant flagged", sawGrant, 1'b1);
    check("ready back high", ready, 1'b1);
    $display("test during done");
  endtask

  task automatic t_ext;
    logic [9:0] firstRow;
    logic       seen;
    do_reset(1'b0, 1'b1);
    seen = 1'b0;
    repeat (800) begin
      @(posedge clk);
      if (refreshActive === 1'b1) seen = 1'b1;
    end
    check("timer disabled", seen, 1'b0);
    for (int k = 0; k < 2; k++) begin
      extRefreshReq <= 1'b1;
      repeat (8) @(posedge clk);
      extRefreshReq <= 1'b0;
      wait_ref(1'b1);
      wait_ref(1'b0);
      if (k == 0) firstRow = refRow;
    end
    check("row counter step", refRow[8:0], 9'(firstRow[8:0] + 9'h001));
    $display("test external done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    arbEdgeStrap = 1'b0;
    refreshSourceStrap = 1'b0;
    extRefreshReq = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_calib();
    t_normal();
    t_during();
    // divisor 61: three device cycles a refresh
    measure(12, 244);
    $display("test rate61 done");
    t_ext();
    do_reset(1'b1, 1'b0);
    // edge high, internal source: divisor 136, four cycles
    measure(16, 544);
    $display("test rate136 done");
    wrap_up();
  end
endmodule
`default_nettype wire
